// *** tws_top.sv ***
// Chosen here: strobed register access.
`timescale 1ns/1ns
`include "tws_params.svh"
// Functional notes
// RULE1 - Stretch status reads one while the slave holds SCL low.
// RULE2 - Address or data event sets stretch; clearing that event drops it; the code drops it only on a slave command or auto-ack data access.
// RULE3 - Received-ack status keeps the master's last ack bit, one for NACK.
// RULE4 - Failed high bit on SDA sets collision; byte-done set at byte end.
// RULE5 - NACK lost after address match sets collision and address/stop flag.
// RULE6 - Collision clears by writing one, or on any Start or repeated Start.
// RULE7 - Start, repeated Start or Stop out of order raises bus error; the code flags only a Stop with no open Start or right after a Start.
// RULE8 - Writing one clears bus error; writing zero leaves it.
// RULE9 - Bus errors need master enabled and clock at least four times SCL.
// RULE10 - Direction status is the read/write bit of the last address.
// RULE11 - Cause bit: zero means Stop, one means address detection.
// RULE12 - Matching address sets address/stop flag and cause bit.
// RULE13 - Own address bits seven to one form the primary address.
// RULE14 - Own address bit zero enables general call match.
// RULE15 - Software touches data only while the slave stretches SCL.
// RULE16 - Auto-ack mode: data read during stretch performs the ack choice.
// RULE17 - Mask mode: mask bits set to one always match.
// RULE18 - Second-address mode: the mask field is another address.
// RULE19 - Mask register bits seven to one hold field, bit zero select.
// RULE20 - Match-any setting accepts every address.
// RULE21 - Data access or slave command clears byte-done and address/stop.
// RULE22 - Ack choice zero sends ACK, one sends NACK.
// RULE23 - Upper seven received bits compared; lowest bit is direction.
module tws_top
    import tws_pkg::*;
(
    input  wire logic       clk_i,       // Clock, 20 MHz.
    input  wire logic       rstn_i,      // Asynchronous reset, active low.
    input  wire logic       ce_i,        // Clock enable, freezes all state.
    input  wire logic [7:0] addr_i,      // Register address.
    input  wire logic [7:0] wdata_i,     // Register write data.
    input  wire logic       we_i,        // Write strobe.
    input  wire logic       re_i,        // Read strobe.
    output logic      [7:0] rdata_o,     // Read data, cycle after the strobe.
    input  wire logic       scl_i,       // Bus clock level.
    output logic            scl_o,       // Bus clock drive value, always low.
    output logic            scl_oe_n_o,  // Bus clock drive enable, active low.
    input  wire logic       sda_i,       // Bus data level.
    output logic            sda_o,       // Bus data drive value, always low.
    output logic            sda_oe_n_o   // Bus data drive enable, active low.
);

    tws_state_e  state_q;
    logic [3:0]  cnt_q;
    logic [7:0]  shreg_q;
    logic        comp_q;
    logic        addr_ack_q;
    logic        abort_q;
    logic        line_low_q;
    logic [7:0]  own_q;
    logic [7:0]  mask_q;
    logic [7:0]  data_q;
    logic [7:0]  ctrla_q;
    logic        ack_choice_q;
    logic        mstr_en_q;
    logic        dif_q;
    logic        address_stop_flag_q;
    logic        ap_q;
    logic        dir_q;
    logic        master_ack_seen_q;
    logic        lost_drive_flag_q;
    logic        berr_q;
    logic        busy_q;
    logic        gotbit_q;
    logic        scl_p_q;
    logic        sda_p_q;
    logic [1:0]  pins_s;
    logic        scl_s;
    logic        sda_s;
    logic        hit;
    logic        hold;

    tws_sync #(
        .W      (2)
    ) u_sync (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .ce_i   (ce_i),
        .d_i    ({scl_i, sda_i}),
        .q_o    (pins_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    tws_match u_match (
        .rx_addr_i (shreg_q[7:1]),
        .own_i     (own_q),
        .mask_i    (mask_q),
        .any_i     (ctrla_q[`TWS_CA_ANY]),
        .hit_o     (hit)
    );

    // Bus conditions, seen on the synchronised pins only.
    logic scl_rise, scl_fall, start_ev, stop_ev, run;
    assign scl_rise = ce_i && scl_s && !scl_p_q;
    assign scl_fall = ce_i && !scl_s && scl_p_q;
    assign start_ev = ce_i && scl_s && scl_p_q && sda_p_q && !sda_s;
    assign stop_ev  = ce_i && scl_s && scl_p_q && !sda_p_q && sda_s;
    assign run      = ctrla_q[`TWS_CA_EN] && !start_ev && !stop_ev;
    assign hold     = (state_q == S_AHOLD) || (state_q == S_DHOLD);

    // Register port decode.
    logic wr_data, rd_data, wr_ctrlb, wr_stat, cmd_go, comp_cmd, ack_eff;
    logic smart_go, go, flag_clr;
    logic [7:0] tx_byte;
    assign wr_data  = ce_i && we_i && (addr_i == `TWS_OFF_DATA);
    assign rd_data  = ce_i && re_i && (addr_i == `TWS_OFF_DATA);
    assign wr_ctrlb = ce_i && we_i && (addr_i == `TWS_OFF_CTRLB);
    assign wr_stat  = ce_i && we_i && (addr_i == `TWS_OFF_STATUS);
    assign cmd_go   = wr_ctrlb && ((wdata_i[1:0] == `TWS_CMD_COMP) ||
                                   (wdata_i[1:0] == `TWS_CMD_RESP));
    assign comp_cmd = cmd_go && (wdata_i[1:0] == `TWS_CMD_COMP);
    // A choice written with the command takes effect before the command.
    assign ack_eff  = wr_ctrlb ? wdata_i[`TWS_CB_ACK] : ack_choice_q;
    assign flag_clr = wr_data || rd_data || cmd_go; // [RULE21]
    // In auto-ack mode a transmitter continues on a data write, otherwise on a read.
    assign smart_go = ctrla_q[`TWS_CA_AUTO] &&
                      ((dir_q && state_q == S_DHOLD) ? wr_data : rd_data); // [RULE16]
    assign go       = cmd_go || smart_go;
    assign tx_byte  = wr_data ? wdata_i : data_q;

    // Flag events.
    logic addr_hit, rx_done, rd_first, mack_done, mack_rise;
    logic tx_lost_drive_flag, nack_lost_drive_flag, stop_ap, berr_ev;
    assign addr_hit  = run && state_q == S_ADDR && scl_fall &&
                       cnt_q == `TWS_BYTE_BITS && hit;
    assign rx_done   = run && state_q == S_RX && scl_fall && cnt_q == `TWS_BYTE_BITS;
    assign rd_first  = run && state_q == S_ACK && scl_fall && !comp_q && dir_q;
    assign mack_done = run && state_q == S_MACK && scl_fall;
    assign mack_rise = run && state_q == S_MACK && scl_rise;
    assign tx_lost_drive_flag   = run && state_q == S_TX && scl_rise && sda_oe_n_o &&
                       !sda_s && !abort_q; // [RULE4]
    assign nack_lost_drive_flag = run && state_q == S_ACK && addr_ack_q && scl_rise &&
                       sda_oe_n_o && !sda_s; // [RULE5]
    assign stop_ap   = stop_ev && ctrla_q[`TWS_CA_EN] && ctrla_q[`TWS_CA_STOPEN] &&
                       state_q != S_IDLE;
    // A Stop with no open Start, or right after a Start, is a violation.
    assign berr_ev   = stop_ev && mstr_en_q && (!busy_q || !gotbit_q); // [RULE7] [RULE9]

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            scl_p_q    <= 1'b1;
            sda_p_q    <= 1'b1;
            line_low_q <= 1'b0;
        end
        else if (ce_i)
        begin
            scl_p_q    <= scl_s;
            sda_p_q    <= sda_s;
            line_low_q <= 1'b0;
        end
    end

    assign scl_o = line_low_q;
    assign sda_o = line_low_q;

    // Protocol state machine.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_q    <= S_IDLE;
            cnt_q      <= 4'h0;
            shreg_q    <= `TWS_RST_BYTE;
            sda_oe_n_o <= 1'b1;
            scl_oe_n_o <= 1'b1;
            comp_q     <= 1'b0;
            addr_ack_q <= 1'b0;
            abort_q    <= 1'b0;
        end
        else if (ce_i)
        begin
            if (!ctrla_q[`TWS_CA_EN] || stop_ev)
            begin
                state_q    <= S_IDLE;
                sda_oe_n_o <= 1'b1;
                scl_oe_n_o <= 1'b1;
            end
            else if (start_ev)
            begin
                state_q    <= S_ADDR;
                cnt_q      <= 4'h0;
                sda_oe_n_o <= 1'b1;
                scl_oe_n_o <= 1'b1;
            end
            else
            begin
                unique case (state_q)
                    S_IDLE:
                    begin
                    end
                    S_ADDR, S_RX:
                    begin
                        if (scl_rise)
                        begin
                            shreg_q <= {shreg_q[6:0], sda_s}; // [RULE23]
                            cnt_q   <= cnt_q + 4'h1;
                        end
                        else if (scl_fall && cnt_q == `TWS_BYTE_BITS)
                        begin
                            if (state_q == S_RX)
                            begin
                                state_q    <= S_DHOLD;
                                scl_oe_n_o <= 1'b0; // [RULE1] [RULE2]
                            end
                            else if (hit)
                            begin
                                state_q    <= S_AHOLD;
                                scl_oe_n_o <= 1'b0; // [RULE1] [RULE2]
                            end
                            else
                            begin
                                state_q <= S_IDLE;
                            end
                        end
                    end
                    S_AHOLD, S_DHOLD:
                    begin
                        if (go)
                        begin
                            scl_oe_n_o <= 1'b1; // [RULE2]
                            comp_q     <= comp_cmd;
                            addr_ack_q <= (state_q == S_AHOLD);
                            if (dir_q && (comp_cmd || state_q == S_DHOLD))
                            begin
                                if (comp_cmd)
                                begin
                                    state_q <= S_IDLE;
                                end
                                else
                                begin
                                    state_q    <= S_TX;
                                    shreg_q    <= tx_byte;
                                    sda_oe_n_o <= tx_byte[7];
                                    cnt_q      <= 4'h0;
                                    abort_q    <= 1'b0;
                                end
                            end
                            else
                            begin
                                state_q    <= S_ACK;
                                sda_oe_n_o <= ack_eff; // [RULE22]
                            end
                        end
                    end
                    S_ACK:
                    begin
                        if (scl_fall)
                        begin
                            sda_oe_n_o <= 1'b1;
                            cnt_q      <= 4'h0;
                            if (comp_q)
                            begin
                                state_q <= S_IDLE;
                            end
                            else if (dir_q)
                            begin
                                state_q    <= S_DHOLD;
                                scl_oe_n_o <= 1'b0;
                            end
                            else
                            begin
                                state_q <= S_RX;
                            end
                        end
                    end
                    S_TX:
                    begin
                        if (tx_lost_drive_flag)
                        begin
                            abort_q <= 1'b1; // [RULE4]
                        end
                        if (scl_fall)
                        begin
                            if (cnt_q == `TWS_LAST_TXBIT)
                            begin
                                state_q    <= S_MACK;
                                sda_oe_n_o <= 1'b1;
                            end
                            else
                            begin
                                cnt_q      <= cnt_q + 4'h1;
                                shreg_q    <= {shreg_q[6:0], 1'b0};
                                sda_oe_n_o <= shreg_q[6] || abort_q;
                            end
                        end
                    end
                    S_MACK:
                    begin
                        if (scl_fall)
                        begin
                            state_q    <= S_DHOLD;
                            scl_oe_n_o <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end

    // Status flags; in each flag a set in the same cycle beats a clear.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            dif_q   <= 1'b0;
            address_stop_flag_q  <= 1'b0;
            ap_q    <= 1'b0;
            dir_q   <= 1'b0;
            master_ack_seen_q <= 1'b0;
            lost_drive_flag_q  <= 1'b0;
            berr_q  <= 1'b0;
        end
        else if (ce_i)
        begin
            if (flag_clr)
            begin
                dif_q  <= 1'b0; // [RULE21]
                address_stop_flag_q <= 1'b0; // [RULE21]
            end
            if ((wr_stat && wdata_i[`TWS_ST_LOST_DRIVE_FLAG]) || start_ev)
            begin
                lost_drive_flag_q <= 1'b0; // [RULE6]
            end
            if (wr_stat && wdata_i[`TWS_ST_BERR])
            begin
                berr_q <= 1'b0; // [RULE8]
            end
            if (rx_done || rd_first || mack_done)
            begin
                dif_q <= 1'b1; // [RULE4]
            end
            if (addr_hit || nack_lost_drive_flag)
            begin
                address_stop_flag_q <= 1'b1; // [RULE12] [RULE5]
                ap_q   <= 1'b1; // [RULE11]
            end
            else if (stop_ap)
            begin
                address_stop_flag_q <= 1'b1;
                ap_q   <= 1'b0; // [RULE11]
            end
            if (addr_hit)
            begin
                dir_q <= shreg_q[0]; // [RULE10] [RULE23]
            end
            if (mack_rise)
            begin
                master_ack_seen_q <= sda_s; // [RULE3]
            end
            if (tx_lost_drive_flag || nack_lost_drive_flag)
            begin
                lost_drive_flag_q <= 1'b1; // [RULE4] [RULE5]
            end
            if (berr_ev)
            begin
                berr_q <= 1'b1; // [RULE7]
            end
        end
    end

    // Start/Stop order tracking for the violation detector.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            busy_q   <= 1'b0;
            gotbit_q <= 1'b0;
        end
        else if (start_ev)
        begin
            busy_q   <= 1'b1;
            gotbit_q <= 1'b0;
        end
        else if (stop_ev)
        begin
            busy_q <= 1'b0;
        end
        else if (scl_rise)
        begin
            gotbit_q <= 1'b1;
        end
    end

    // Software-written configuration and the data byte.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            own_q        <= `TWS_RST_BYTE;
            mask_q       <= `TWS_RST_BYTE;
            data_q       <= `TWS_RST_BYTE;
            ctrla_q      <= `TWS_RST_BYTE;
            ack_choice_q <= 1'b0;
            mstr_en_q    <= 1'b0;
        end
        else if (ce_i)
        begin
            if (we_i && addr_i == `TWS_OFF_ADDR)
            begin
                own_q <= wdata_i; // [RULE13] [RULE14]
            end
            if (we_i && addr_i == `TWS_OFF_MASK)
            begin
                mask_q <= wdata_i; // [RULE17] [RULE18] [RULE19]
            end
            if (we_i && addr_i == `TWS_OFF_CTRLA)
            begin
                ctrla_q <= wdata_i & 8'h27; // [RULE20]
            end
            if (wr_ctrlb)
            begin
                ack_choice_q <= wdata_i[`TWS_CB_ACK]; // [RULE22]
            end
            if (we_i && addr_i == `TWS_OFF_MCTRL)
            begin
                mstr_en_q <= wdata_i[`TWS_MC_EN];
            end
            if (rx_done)
            begin
                data_q <= shreg_q;
            end
            else if (wr_data)
            begin
                data_q <= wdata_i;
            end
        end
    end

    // Read data stands for exactly one cycle after the strobe.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rdata_o <= `TWS_RST_BYTE;
        end
        else if (ce_i)
        begin
            rdata_o <= `TWS_RST_BYTE;
            if (re_i)
            begin
                unique case (addr_i)
                    `TWS_OFF_MCTRL:  rdata_o <= {7'h00, mstr_en_q};
                    `TWS_OFF_CTRLA:  rdata_o <= ctrla_q;
                    `TWS_OFF_CTRLB:  rdata_o <= {5'h00, ack_choice_q, 2'h0};
                    `TWS_OFF_STATUS: rdata_o <= {dif_q, address_stop_flag_q, hold, master_ack_seen_q,
                                                 lost_drive_flag_q, berr_q, dir_q, ap_q}; // [RULE1]
                    `TWS_OFF_ADDR:   rdata_o <= own_q;
                    `TWS_OFF_DATA:   rdata_o <= data_q;
                    `TWS_OFF_MASK:   rdata_o <= mask_q;
                    default:         rdata_o <= `TWS_RST_BYTE;
                endcase
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    property p_hold_read;
        (ce_i && re_i && addr_i == `TWS_OFF_STATUS) |=>
            rdata_o[`TWS_ST_HOLD] == !$past(scl_oe_n_o);
    endproperty
    a_hold_read: assert property (p_hold_read) else $error("stretch bit wrong"); // [RULE1]

    property p_addr_stretch;
        addr_hit |=> (state_q == S_AHOLD) && !scl_oe_n_o && address_stop_flag_q;
    endproperty
    a_addr_stretch: assert property (p_addr_stretch) else $error("no stretch"); // [RULE2]

    property p_master_ack_seen;
        mack_rise |=> master_ack_seen_q == $past(sda_s);
    endproperty
    a_master_ack_seen: assert property (p_master_ack_seen) else $error("ack not kept"); // [RULE3]

    property p_lost_drive_flag_start;
        start_ev && !tx_lost_drive_flag && !nack_lost_drive_flag |=> !lost_drive_flag_q;
    endproperty
    a_lost_drive_flag_start: assert property (p_lost_drive_flag_start) else $error("lost_drive_flag kept"); // [RULE6]

    property p_berr_keep;
        (berr_q && wr_stat && !wdata_i[`TWS_ST_BERR]) |=> berr_q;
    endproperty
    a_berr_keep: assert property (p_berr_keep) else $error("bus error lost"); // [RULE8]

    property p_addr_flags;
        addr_hit |=> address_stop_flag_q && ap_q ##1 (address_stop_flag_q || $past(flag_clr));
    endproperty
    a_addr_flags: assert property (p_addr_flags) else $error("flags not set"); // [RULE12]

    property p_dir;
        addr_hit |=> dir_q == $past(shreg_q[0]);
    endproperty
    a_dir: assert property (p_dir) else $error("direction wrong"); // [RULE10]

    property p_flag_clr;
        (flag_clr && !(rx_done || rd_first || mack_done)) |=> !dif_q;
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("byte flag kept"); // [RULE21]

endmodule

// *** tws_params.svh ***
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH

// Register offsets on the plain register port.
`define TWS_OFF_MCTRL   8'h03
`define TWS_OFF_CTRLA   8'h09
`define TWS_OFF_CTRLB   8'h0A
`define TWS_OFF_STATUS  8'h0B
`define TWS_OFF_ADDR    8'h0C
`define TWS_OFF_DATA    8'h0D
`define TWS_OFF_MASK    8'h0E

// Control A fields.
`define TWS_CA_STOPEN   5
`define TWS_CA_ANY      2
`define TWS_CA_AUTO     1
`define TWS_CA_EN       0

// Control B fields and command codes.
`define TWS_CB_ACK      2
`define TWS_CMD_COMP    2'h2
`define TWS_CMD_RESP    2'h3

// Master control field.
`define TWS_MC_EN       0

// Status fields.
`define TWS_ST_DIF      7
`define TWS_ST_ADDRESS_STOP_FLAG     6
`define TWS_ST_HOLD     5
`define TWS_ST_MASTER_ACK_SEEN    4
`define TWS_ST_LOST_DRIVE_FLAG     3
`define TWS_ST_BERR     2
`define TWS_ST_DIR      1
`define TWS_ST_AP       0

// Reset values, counts and the general call address.
`define TWS_RST_BYTE    8'h00
`define TWS_BYTE_BITS   4'h8
`define TWS_LAST_TXBIT  4'h7
`define TWS_GENCALL     7'h00

`endif

// *** tws_pkg.sv ***
package tws_pkg;

    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_AHOLD,
        S_ACK,
        S_RX,
        S_DHOLD,
        S_TX,
        S_MACK
    } tws_state_e;

endpackage

// *** tws_sync.sv ***
`timescale 1ns/1ns
module tws_sync
    import tws_pkg::*;
#(
    parameter int W = 2
)
(
    input  wire logic         clk_i,   // Clock.
    input  wire logic         rstn_i,  // Asynchronous reset, active low.
    input  wire logic         ce_i,    // Clock enable.
    input  wire logic [W-1:0] d_i,     // Asynchronous inputs.
    output logic      [W-1:0] q_o      // Synchronised outputs.
);

    logic [W-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            meta_q <= '1;
            q_o    <= '1;
        end
        else if (ce_i)
        begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end

endmodule

// *** tws_match.sv ***
`timescale 1ns/1ns
`include "tws_params.svh"
module tws_match
    import tws_pkg::*;
(
    input  wire logic [6:0] rx_addr_i,  // Upper seven bits of the address byte.
    input  wire logic [7:0] own_i,      // Own address register.
    input  wire logic [7:0] mask_i,     // Mask or second address register.
    input  wire logic       any_i,      // Match any address.
    output logic            hit_o       // Address matched.
);

    logic own_hit;
    logic gen_hit;
    logic sec_hit;

    always_comb
    begin
        gen_hit = own_i[0] && (rx_addr_i == `TWS_GENCALL);
        if (mask_i[0])
        begin
            own_hit = (rx_addr_i == own_i[7:1]);
            sec_hit = (rx_addr_i == mask_i[7:1]);
        end
        else
        begin
            // Masked bits always compare equal, so ranges can be recognised.
            own_hit = (((rx_addr_i ^ own_i[7:1]) & ~mask_i[7:1]) == 7'h00);
            sec_hit = 1'b0;
        end
        hit_o = any_i || gen_hit || own_hit || sec_hit;
    end

endmodule

// *** tws_master_model.sv ***
`timescale 1ns/1ns
module tws_master_model
(
    input  wire logic scl_w,  // Bus clock wire level.
    output logic      scl_m,  // Bus clock drive, high releases.
    output logic      sda_m   // Bus data drive, high releases.
);
    initial
    begin
        scl_m = 1'b1;
        sda_m = 1'b1;
    end
    // Each phase is 200 ns, four main clocks, so the slave sees every edge.
    task start();
        #210 sda_m = 1'b0;
        #200 scl_m = 1'b0;
    endtask
    // SDA moves well after SCL falls so the slave never mistakes it for a Start.
    task bit_out(input logic b);
        #50 sda_m = b;
        #150 scl_m = 1'b1;
        wait (scl_w);
        #200 scl_m = 1'b0;
    endtask
    task put_byte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--)
            bit_out(v[i]);
    endtask
    task stop();
        #50 sda_m = 1'b0;
        #200 scl_m = 1'b1;
        #200 sda_m = 1'b1;
    endtask
    task start_stop();
        #210 sda_m = 1'b0;
        #200 sda_m = 1'b1;
    endtask
endmodule

// *** test_two_wire_slave_status_match.sv ***
`timescale 1ns/1ns
module test_two_wire_slave_status_match;
    import tws_pkg::*;
    logic       clk_i = 1'b0, rstn_i = 1'b0, we_i = 1'b0, re_i = 1'b0, ce_i = 1'b1, dir;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, d;
    logic       scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, scl_m, sda_m;
    wire        scl_w = scl_m & (scl_oe_n_o | scl_o);
    wire        sda_w = sda_m & (sda_oe_n_o | sda_o);
    int         n_errors = 0, n_compared = 0, cyc = 0;
    // Row: hit, control A, own address, mask, address byte.
    logic [32:0] rows [8] = '{
        33'h1_0154_0054,
        33'h0_0154_0057,
        33'h1_0154_0257,
        33'h1_0154_6160,
        33'h0_0154_6060,
        33'h1_0155_0000,
        33'h0_0154_0000,
        33'h1_0554_00EF};
    always #25 clk_i = ~clk_i;
    tws_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .scl_i(scl_w),
        .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n_o));
    tws_master_model m (.scl_w(scl_w), .scl_m(scl_m), .sda_m(sda_m));
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= v;
        we_i    <= 1'b1;
        @(posedge clk_i);
        we_i    <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk_i);
        addr_i <= a;
        re_i   <= 1'b1;
        @(posedge clk_i);
        re_i   <= 1'b0;
        #1 d = rdata_o;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        if (got !== exp)
            n_errors++;
    endtask
    // A miss never stretches, so this also bounds the wait for a refused address.
    task hold_wait();
        for (int i = 0; i < 24 && scl_oe_n_o !== 1'b0; i++)
            @(posedge clk_i);
    endtask
    task report_and_stop();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            n_errors++;
            report_and_stop();
        end
    end
    initial
    begin
        repeat (5) @(posedge clk_i);
        rstn_i <= 1'b1;
        for (int a = 11; a < 15; a++)
        begin
            rd(8'(a));
            chk(d, 8'h00);
        end
        rd(8'h20);
        chk(d, 8'h00);
        dir = 1'b0;
        foreach (rows[r])
        begin
            wr(8'h09, rows[r][31:24]);
            wr(8'h0C, rows[r][23:16]);
            wr(8'h0E, rows[r][15:8]);
            m.start();
            m.put_byte(rows[r][7:0]);
            hold_wait();
            rd(8'h0B);
            if (rows[r][32])
                dir = rows[r][0];
            if (rows[r][32])
                chk(d & 8'hE3, {6'b011000, dir, 1'b1});
            else
                chk(d & 8'hE2, {6'b000000, dir, 1'b0});
            if (rows[r][32])
                wr(8'h0A, 8'h02);
            m.bit_out(1'b1);
            m.stop();
            $display("address row %0d done", r);
        end
        wr(8'h09, 8'h23);
        m.start();
        m.put_byte(8'h54);
        hold_wait();
        rd(8'h0D);
        chk({7'h00, sda_oe_n_o}, 8'h00);
        rd(8'h0B);
        chk(d & 8'hE0, 8'h00);
        m.bit_out(1'b1);
        m.put_byte(8'hA5);
        hold_wait();
        rd(8'h0B);
        chk(d & 8'hE0, 8'hA0);
        rd(8'h0D);
        chk(d, 8'hA5);
        m.bit_out(1'b1);
        m.stop();
        // A bus condition takes three clocks to reach the flags.
        repeat (4) @(posedge clk_i);
        rd(8'h0B);
        chk(d & 8'h41, 8'h40);
        $display("receive test done");
        wr(8'h09, 8'h01);
        m.start();
        m.put_byte(8'h55);
        hold_wait();
        wr(8'h0A, 8'h03);
        m.bit_out(1'b1);
        hold_wait();
        wr(8'h0D, 8'hC3);
        wr(8'h0A, 8'h03);
        // The master pulls the first bit low while the slave sends a one.
        m.put_byte(8'h7F);
        m.bit_out(1'b1);
        hold_wait();
        rd(8'h0B);
        chk(d, 8'hBB);
        wr(8'h0A, 8'h02);
        m.stop();
        $display("transmit test done");
        wr(8'h03, 8'h01);
        m.start_stop();
        repeat (4) @(posedge clk_i);
        rd(8'h0B);
        chk(d & 8'h0C, 8'h04);
        wr(8'h0B, 8'h00);
        rd(8'h0B);
        chk(d & 8'h04, 8'h04);
        @(posedge clk_i) ce_i <= 1'b0;
        wr(8'h0B, 8'h04);
        ce_i <= 1'b1;
        rd(8'h0B);
        chk(d & 8'h04, 8'h04);
        wr(8'h0B, 8'h04);
        rd(8'h0B);
        chk(d & 8'h04, 8'h00);
        $display("bus error test done");
        @(posedge clk_i) rstn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        rd(8'h0B);
        chk(d, 8'h00);
        $display("reset test done");
        report_and_stop();
    end
endmodule
